// ===== cgr_global_regs.sv
// global configuration and signalling registers of a quad pcm codec
// assumes a host byte-command port on the same clock, one command a cycle
`timescale 1ns/1ps
module cgr_global_regs
  import cgr_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           rst_b_in,
  input  wire logic           cmd_valid_in,
  input  wire logic [7:0]     cmd_byte_in,
  input  wire logic [7:0]     wr_data_in,
  output logic      [7:0]     rd_data_out,
  output logic                rd_valid_out,
  input  wire logic           local_req_in,
  output logic      [NCH-1:0] local_req_ch_out,
  output logic      [NCH-1:0] ch_prog_en_out,
  output logic      [3:0]     mclk_sel_out,
  output cgr_mclk_t           mclk_out,
  output cgr_pcm_cfg_t        pcm_cfg_out,
  input  wire logic [NCH-1:0] hook_in_pin_in,
  input  wire logic [NCH-1:0] gndkey_in_pin_in,
  input  wire logic [NCH-1:0] sig_bank_one_pin_in,
  output logic      [NCH-1:0] sig_bank_one_pin_out,
  output logic      [NCH-1:0] sig_bank_one_pin_oe_out,
  input  wire logic [NCH-1:0] sig_bank_two_pin_in,
  output logic      [NCH-1:0] sig_bank_two_pin_out,
  output logic      [NCH-1:0] sig_bank_two_pin_oe_out,
  input  wire logic [NCH-1:0] ring_req_in,
  input  wire logic [NCH-1:0] sig_bank_three_dir_in,
  output logic      [NCH-1:0] sig_bank_three_force_out,
  output logic                sig_bank_three_level_out,
  output logic      [NCH-1:0] fixed_out_a_out,
  output logic      [NCH-1:0] fixed_out_b_out,
  output logic      [NCH-1:0] ring_trip_out
);
  logic [7:0]     clk_ce_q;
  logic [7:0]     pcm_q;
  logic [7:0]     ring_q;
  logic [7:0]     bank1_q;
  logic [7:0]     bank2_q;
  logic [NCH-1:0] trip_q;
  logic [NCH-1:0] hook_deb;
  logic [NCH-1:0] gk_deb;
  logic [NCH-1:0] b1_sync;
  logic [NCH-1:0] b2_sync;
  logic [NCH-1:0] b1_rd;
  logic [NCH-1:0] b2_rd;
  logic [NCH-1:0] hook_src;
  logic [NCH-1:0] offhook;
  logic [NCH-1:0] force_b1;
  logic [NCH-1:0] force_b2;
  logic [6:0]     addr;
  logic           is_wr;
  logic           is_rd;
  logic           wr_ce;
  logic           wr_pcm;
  logic           wr_ring;
  logic           wr_b1;
  logic           wr_b2;
  logic           rd_hit;
  logic [7:0]     rd_mux;
  logic [2:0]     pick;
  logic           ring_pol;
  logic           act_lvl;

  // R21 command decode
  assign addr    = cmd_byte_in[6:0];
  assign is_wr   = cmd_valid_in && cmd_byte_in[CMD_WR_POS];
  assign is_rd   = cmd_valid_in && !cmd_byte_in[CMD_WR_POS];
  assign wr_ce   = is_wr && addr == REG_CLK_CE;
  assign wr_pcm  = is_wr && addr == REG_PCM;
  assign wr_ring = is_wr && addr == REG_RING;
  assign wr_b1   = is_wr && addr == REG_BANK1;
  assign wr_b2   = is_wr && addr == REG_BANK2;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clk_ce_q <= RST_CLK_CE;
    end else if (wr_ce) begin
      clk_ce_q <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pcm_q <= RST_PCM;
    end else if (wr_pcm) begin
      pcm_q <= wr_data_in;
    end
  end

  // reserved bit kept at zero so it always reads back clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ring_q <= RST_RING;
    end else if (wr_ring) begin
      ring_q <= wr_data_in & RING_RSVD_MASK;
    end
  end

  // R17 bank one direction and data
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bank1_q <= RST_BANK;
    end else if (wr_b1) begin
      bank1_q <= wr_data_in;
    end
  end

  // R19 bank two direction and data
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bank2_q <= RST_BANK;
    end else if (wr_b2) begin
      bank2_q <= wr_data_in;
    end
  end

  // R1 channel enable gate
  assign ch_prog_en_out   = clk_ce_q[CE_LSB +: NCH];
  assign local_req_ch_out = {NCH{local_req_in}} & ch_prog_en_out;

  // R2 master clock decode
  assign mclk_sel_out = clk_ce_q[SEL_LSB +: 4];
  always_comb begin
    mclk_out.ok = 1'b1;
    case (mclk_sel_out)
      MC_8192: mclk_out.khz = 14'd8192;
      MC_4096: mclk_out.khz = 14'd4096;
      MC_2048: mclk_out.khz = 14'd2048;
      MC_1536: mclk_out.khz = 14'd1536;
      MC_1544: mclk_out.khz = 14'd1544;
      MC_3072: mclk_out.khz = 14'd3072;
      MC_3088: mclk_out.khz = 14'd3088;
      MC_6144: mclk_out.khz = 14'd6144;
      MC_6176: mclk_out.khz = 14'd6176;
      default: begin
        mclk_out.khz = 14'd0;
        mclk_out.ok  = 1'b0;
      end
    endcase
  end

  // R3 law select
  assign pcm_cfg_out.law_mu       = pcm_q[LAW_POS];
  // R4 voice format
  assign pcm_cfg_out.voice_linear = pcm_q[VFMT_POS];
  // R5 single or double
  assign pcm_cfg_out.double_clk   = pcm_q[DBL_POS];
  // R6 edge choice
  assign pcm_cfg_out.tx_falling   = pcm_q[EDGE_LSB + 1];
  assign pcm_cfg_out.rx_rising    = pcm_q[EDGE_LSB];
  // R7 slot offset
  assign pcm_cfg_out.slot_offset  = pcm_q[OFS_LSB +: 3];

  // hook and ground key pins get the long hold-off filter
  cgr_in_sync #(
    .W       (2 * NCH),
    .DEB_CNT (DEB_CYCLES)
  ) u_hook_sync (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .pin_in    ({gndkey_in_pin_in, hook_in_pin_in}),
    .level_out ({gk_deb, hook_deb})
  );

  cgr_in_sync #(
    .W       (2 * NCH),
    .DEB_CNT (PIN_CYCLES)
  ) u_bank_sync (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .pin_in    ({sig_bank_two_pin_in, sig_bank_one_pin_in}),
    .level_out ({b2_sync, b1_sync})
  );

  assign pick     = ring_q[PICK_LSB +: 3];
  assign ring_pol = ring_q[RPOL_POS];
  // R8 active level
  assign act_lvl  = ~ring_pol;

  // R10 hook source pick
  assign hook_src = ring_q[SRC_POS] ? gk_deb : hook_deb;
  // R9 hook polarity
  assign offhook  = ring_q[HPOL_POS] ? hook_src : ~hook_src;

  // R11 R14 trip latch follows the off-hook level while enabled
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trip_q <= '0;
    end else begin
      trip_q <= ring_q[TRIP_POS] ? offhook : '0;
    end
  end
  assign ring_trip_out = trip_q;

  // R12 R13 bank outputs forced inactive only when set as outputs
  assign force_b1 = (pick == PICK_B1) ? (trip_q & bank1_q[DIR_LSB +: NCH])
                                      : '0;
  assign force_b2 = (pick == PICK_B2) ? (trip_q & bank2_q[DIR_LSB +: NCH])
                                      : '0;

  // R18 bank one pins
  cgr_sig_bank u_bank1 (
    .clk_in         (clk_in),
    .rst_b_in       (rst_b_in),
    .dir_in         (bank1_q[DIR_LSB +: NCH]),
    .data_in        (bank1_q[DATA_LSB +: NCH]),
    .force_in       (force_b1),
    .force_level_in (ring_pol),
    .pin_sync_in    (b1_sync),
    .pin_out        (sig_bank_one_pin_out),
    .pin_oe_out     (sig_bank_one_pin_oe_out),
    .readback_out   (b1_rd)
  );

  // R20 bank two pins
  cgr_sig_bank u_bank2 (
    .clk_in         (clk_in),
    .rst_b_in       (rst_b_in),
    .dir_in         (bank2_q[DIR_LSB +: NCH]),
    .data_in        (bank2_q[DATA_LSB +: NCH]),
    .force_in       (force_b2),
    .force_level_in (ring_pol),
    .pin_sync_in    (b2_sync),
    .pin_out        (sig_bank_two_pin_out),
    .pin_oe_out     (sig_bank_two_pin_oe_out),
    .readback_out   (b2_rd)
  );

  // R12 R14 bank three override and fixed outputs
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sig_bank_three_force_out <= '0;
      sig_bank_three_level_out <= 1'b0;
      fixed_out_a_out          <= '0;
      fixed_out_b_out          <= '0;
    end else begin
      sig_bank_three_level_out <= ring_pol;
      sig_bank_three_force_out <= (pick == PICK_B3)
                                  ? (trip_q & sig_bank_three_dir_in) : '0;
      for (int c = 0; c < NCH; c++) begin
        fixed_out_a_out[c] <= (pick == PICK_FA && ring_req_in[c] &&
                               !trip_q[c]) ? act_lvl : ring_pol;
        fixed_out_b_out[c] <= (pick == PICK_FB && ring_req_in[c] &&
                               !trip_q[c]) ? act_lvl : ring_pol;
      end
    end
  end

  // R15 R16 read mux
  always_comb begin
    rd_hit = 1'b1;
    if (addr == REG_CLK_CE) begin
      rd_mux = clk_ce_q;
    end else if (addr == REG_PCM) begin
      rd_mux = pcm_q;
    end else if (addr == REG_RING) begin
      rd_mux = ring_q;
    end else if (addr == REG_STATUS) begin
      rd_mux = {gk_deb, hook_deb};
    end else if (addr == REG_BANK1) begin
      rd_mux = {bank1_q[DIR_LSB +: NCH], b1_rd};
    end else if (addr == REG_BANK2) begin
      rd_mux = {bank2_q[DIR_LSB +: NCH], b2_rd};
    end else begin
      rd_mux = 8'h00;
      rd_hit = 1'b0;
    end
  end

  // other command codes belong to other blocks and get no answer here
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_out  <= 8'h00;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= is_rd && rd_hit;
      if (is_rd && rd_hit) begin
        rd_data_out <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_ce_write: assert property ( // R1
    wr_ce |=> ch_prog_en_out == $past(wr_data_in[7:4]))
    else $error("channel enables did not take written value");

  a_local_gate: assert property ( // R1
    (local_req_in && ch_prog_en_out == 4'h0) |-> local_req_ch_out == 4'h0)
    else $error("local request passed a disabled channel");

  a_mclk_2048: assert property ( // R2
    (wr_ce && wr_data_in[3:0] == 4'h2)
      |=> mclk_out.ok && mclk_out.khz == 14'd2048)
    else $error("clock code 2 did not decode as 2048 kHz");

  a_law_write: assert property ( // R3
    wr_pcm |=> pcm_cfg_out.law_mu == $past(wr_data_in[7]) &&
               pcm_cfg_out.voice_linear == $past(wr_data_in[6]))
    else $error("law or format bit not updated");

  a_edge_pick: assert property ( // R6
    (wr_pcm && wr_data_in[4:3] == 2'h3)
      |=> pcm_cfg_out.tx_falling && pcm_cfg_out.rx_rising)
    else $error("edge code 3 mis-decoded");

  a_slot_write: assert property ( // R7
    wr_pcm |=> pcm_cfg_out.slot_offset == $past(wr_data_in[2:0]))
    else $error("slot offset not updated");

  a_trip_off: assert property ( // R11
    !ring_q[TRIP_POS] |=> trip_q == 4'h0)
    else $error("ring trip active while disabled");

  a_trip_fixed: assert property ( // R14
    (trip_q[0] && pick == PICK_FA && !wr_ring)
      |=> fixed_out_a_out[0] == $past(ring_pol))
    else $error("fixed output not returned to inactive level");

  a_status_read: assert property ( // R15
    (is_rd && addr == REG_STATUS)
      |=> rd_valid_out && rd_data_out == $past({gk_deb, hook_deb}))
    else $error("status read returned wrong value");

  a_bank1_dir: assert property ( // R17
    (wr_b1 ##1 !wr_b1)
      |=> sig_bank_one_pin_oe_out == $past(wr_data_in[7:4], 2))
    else $error("bank one direction not applied to pins");

  a_bank2_dir: assert property ( // R19
    (wr_b2 ##1 !wr_b2)
      |=> sig_bank_two_pin_oe_out == $past(wr_data_in[7:4], 2))
    else $error("bank two direction not applied to pins");

  a_trip_follow: assert property ( // R14
    ring_q[TRIP_POS] |=> trip_q == $past(offhook))
    else $error("ring trip does not follow off-hook level");

  a_bank3_gate: assert property ( // R12
    (pick != PICK_B3) |=> sig_bank_three_force_out == 4'h0)
    else $error("bank three forced while not picked");

  a_fixed_b_idle: assert property ( // R13
    (pick != PICK_FB)
      |=> fixed_out_b_out == ($past(ring_pol) ? 4'hf : 4'h0))
    else $error("unpicked second fixed output not idle");

  a_unmapped_rd: assert property ( // R21
    (is_rd && !rd_hit) |=> !rd_valid_out)
    else $error("unmapped read was answered");
endmodule

// ===== cgr_pkg.sv
// constants, field layout and carrier types for the codec global
// configuration register group; assumes an 8-bit byte-command host port.
// Behaviour
// R1 - four channel program enables, reset clear, gate local register commands
// R2 - four-bit master clock code decodes to nine rates, 2.048 MHz at reset
// R3 - law bit 0 selects A-law (reset), 1 selects mu-law
// R4 - format bit 0 compressed code (reset), 1 linear code
// R5 - slope bit 2: 0 single clock (reset), 1 double clock
// R6 - slope bits 1:0 choose transmit and receive bit clock edges
// R7 - three-bit slot offset delays both time slots 0 to 7 clocks
// R8 - ring polarity 0 activates low-to-high (reset), 1 high-to-low
// R9 - hook polarity 0 active low (reset), 1 active high
// R10 - source pick 0 uses hook input (reset), 1 uses ground-key input
// R11 - ring trip inactive while enable bit 0 (reset), active when 1
// R12 - pick 011 bank one, 101 bank three, 110 fixed output a
// R13 - pick 100 bank two, 111 fixed output b
// R14 - enabled ring trip returns selected output inactive on off-hook
// R15 - status register low nibble shows debounced hook state, channel 1 bit 0
// R16 - status register high nibble shows debounced ground key, channel 1 bit 4
// R17 - bank one direction bit 1 makes pin output, reset input
// R18 - bank one data reads pin when input, drives pin when output
// R19 - bank two direction bit 1 makes pin output, reset input
// R20 - bank two data reads pin when input, drives pin when output
// R21 - command bit 7 selects write; offsets 25h to 2ah, 28h read only
// R22 - host writes zero to reserved bits, ignores them on read
package cgr_pkg;
  localparam int         NCH          = 4;
  localparam int         CMD_WR_POS   = 7;
  localparam logic [6:0] REG_CLK_CE   = 7'h25;
  localparam logic [6:0] REG_PCM      = 7'h26;
  localparam logic [6:0] REG_RING     = 7'h27;
  localparam logic [6:0] REG_STATUS   = 7'h28;
  localparam logic [6:0] REG_BANK1    = 7'h29;
  localparam logic [6:0] REG_BANK2    = 7'h2a;
  // field positions
  localparam int CE_LSB    = 4;
  localparam int SEL_LSB   = 0;
  localparam int LAW_POS   = 7;
  localparam int VFMT_POS  = 6;
  localparam int DBL_POS   = 5;
  localparam int EDGE_LSB  = 3;
  localparam int OFS_LSB   = 0;
  localparam int RPOL_POS  = 7;
  localparam int HPOL_POS  = 5;
  localparam int SRC_POS   = 4;
  localparam int TRIP_POS  = 3;
  localparam int PICK_LSB  = 0;
  localparam int DIR_LSB   = 4;
  localparam int DATA_LSB  = 0;
  // reset values
  localparam logic [7:0] RST_CLK_CE = 8'h02;
  localparam logic [7:0] RST_PCM    = 8'h00;
  localparam logic [7:0] RST_RING   = 8'h00;
  localparam logic [7:0] RST_BANK   = 8'h00;
  localparam logic [7:0] RING_RSVD_MASK = 8'hbf;
  // master clock codes and rates in kHz
  localparam logic [3:0]  MC_8192 = 4'h0;
  localparam logic [3:0]  MC_4096 = 4'h1;
  localparam logic [3:0]  MC_2048 = 4'h2;
  localparam logic [3:0]  MC_1536 = 4'h6;
  localparam logic [3:0]  MC_1544 = 4'he;
  localparam logic [3:0]  MC_3072 = 4'h5;
  localparam logic [3:0]  MC_3088 = 4'hd;
  localparam logic [3:0]  MC_6144 = 4'h4;
  localparam logic [3:0]  MC_6176 = 4'hc;
  // ring output pick codes
  localparam logic [2:0] PICK_B1 = 3'h3;
  localparam logic [2:0] PICK_B2 = 3'h4;
  localparam logic [2:0] PICK_B3 = 3'h5;
  localparam logic [2:0] PICK_FA = 3'h6;
  localparam logic [2:0] PICK_FB = 3'h7;
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DEB_TIME_NS   = 1000;
  localparam int DEB_CYCLES    = (DEB_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int PIN_CYCLES    = 1;

  typedef struct packed {
    logic       law_mu;
    logic       voice_linear;
    logic       double_clk;
    logic       tx_falling;
    logic       rx_rising;
    logic [2:0] slot_offset;
  } cgr_pcm_cfg_t;

  typedef struct packed {
    logic [13:0] khz;
    logic        ok;
  } cgr_mclk_t;
endpackage

// ===== cgr_in_sync.sv
// three-stage synchroniser with agreement check and hold-off filter
// assumes inputs come from pins outside the clock domain
`timescale 1ns/1ps
module cgr_in_sync
  import cgr_pkg::*;
#(
  parameter int W       = 4,
  parameter int DEB_CNT = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  localparam int CW = $clog2(DEB_CNT + 1);
  localparam logic [CW-1:0] LAST = CW'(DEB_CNT - 1);

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic          s1_q;
    logic          s2_q;
    logic          s3_q;
    logic [CW-1:0] cnt_q;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
      end else begin
        s1_q <= pin_in[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
      end
    end
    // a change counts only once stages two and three agree long enough
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        cnt_q        <= '0;
        level_out[i] <= 1'b0;
      end else if (s2_q != s3_q || s3_q == level_out[i]) begin
        cnt_q <= '0;
      end else if (cnt_q == LAST) begin
        cnt_q        <= '0;
        level_out[i] <= s3_q;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule

// ===== cgr_sig_bank.sv
// one bank of four bidirectional signalling pins with ring override
// assumes direction and data registers live in the parent
`timescale 1ns/1ps
module cgr_sig_bank
  import cgr_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           rst_b_in,
  input  wire logic [NCH-1:0] dir_in,
  input  wire logic [NCH-1:0] data_in,
  input  wire logic [NCH-1:0] force_in,
  input  wire logic           force_level_in,
  input  wire logic [NCH-1:0] pin_sync_in,
  output logic      [NCH-1:0] pin_out,
  output logic      [NCH-1:0] pin_oe_out,
  output logic      [NCH-1:0] readback_out
);
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        pin_out[c]    <= 1'b0;
        pin_oe_out[c] <= 1'b0;
      end else begin
        pin_oe_out[c] <= dir_in[c];
        pin_out[c]    <= force_in[c] ? force_level_in : data_in[c];
      end
    end
    // inputs show the pin, outputs show what was written
    assign readback_out[c] = dir_in[c] ? data_in[c] : pin_sync_in[c];
  end
endmodule

// ===== cgr_host_model.sv
// host processor model on the byte-command register port
// assumes the device answers a read in the cycle after the command
`timescale 1ns/1ps
module cgr_host_model
  import cgr_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rd_valid_in,
  input  wire logic [7:0] rd_data_in,
  output logic            cmd_valid_out,
  output logic [7:0]      cmd_byte_out,
  output logic [7:0]      wr_data_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_byte_out  = 8'h00;
    wr_data_out   = 8'h00;
  end

  task automatic wr(input logic [6:0] adr, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (adr == REG_RING) v = d & RING_RSVD_MASK;
    @(posedge clk_in);
    #1;
    cmd_valid_out = 1'b1;
    cmd_byte_out  = {1'b1, adr};
    wr_data_out   = v;
    @(posedge clk_in);
    #1;
    cmd_valid_out = 1'b0;
    // released data no longer shows the last value
    wr_data_out   = ~v;
  endtask

  task automatic rd(input  logic [6:0] adr,
                    output logic [7:0] d,
                    output logic       got);
    @(posedge clk_in);
    #1;
    // read flag clear in bit 7
    cmd_valid_out = 1'b1;
    cmd_byte_out  = {1'b0, adr};
    @(posedge clk_in);
    #1;
    got           = rd_valid_in;
    d             = rd_data_in;
    cmd_valid_out = 1'b0;
  endtask
endmodule

// ===== tb.sv
// self-checking bench for the global configuration register group
// assumes cgr_host_model drives the command port; pins are modelled here
`timescale 1ns/1ps
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin \
  err_count++; $display("[ERR] %0t %s", $time, m); end end
module tb
  import cgr_pkg::*;
;
  logic         clk_in, rst_b_in, local_req_in, cmd_valid, rd_valid;
  logic [7:0]   cmd_byte, wr_data, rd_data;
  logic [3:0]   hook, gk, ring_req, ext1, ext2, lreq_ch, ch_en, mclk_sel;
  logic [3:0]   b1_out, b1_oe, b2_out, b2_oe, b3_force, fa, fb, trip;
  logic         b3_lvl;
  logic [3:0]   b3_dir;
  cgr_mclk_t    mclk;
  cgr_pcm_cfg_t pcm;
  int           err_count = 0;
  int           num_checks = 0;
  // far-side drivers give way wherever the device drives
  wire  [3:0]   b1_pin = (b1_oe & b1_out) | (~b1_oe & ext1);
  wire  [3:0]   b2_pin = (b2_oe & b2_out) | (~b2_oe & ext2);

  cgr_host_model host (.clk_in(clk_in), .rd_valid_in(rd_valid),
    .rd_data_in(rd_data), .cmd_valid_out(cmd_valid),
    .cmd_byte_out(cmd_byte), .wr_data_out(wr_data));

  cgr_global_regs dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .cmd_valid_in(cmd_valid), .cmd_byte_in(cmd_byte),
    .wr_data_in(wr_data), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .local_req_in(local_req_in), .local_req_ch_out(lreq_ch),
    .ch_prog_en_out(ch_en), .mclk_sel_out(mclk_sel), .mclk_out(mclk),
    .pcm_cfg_out(pcm), .hook_in_pin_in(hook), .gndkey_in_pin_in(gk),
    .sig_bank_one_pin_in(b1_pin), .sig_bank_one_pin_out(b1_out),
    .sig_bank_one_pin_oe_out(b1_oe), .sig_bank_two_pin_in(b2_pin),
    .sig_bank_two_pin_out(b2_out), .sig_bank_two_pin_oe_out(b2_oe),
    .ring_req_in(ring_req), .sig_bank_three_dir_in(b3_dir),
    .sig_bank_three_force_out(b3_force),
    .sig_bank_three_level_out(b3_lvl),
    .fixed_out_a_out(fa), .fixed_out_b_out(fb), .ring_trip_out(trip));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       g;
    host.rd(a, d, g);
    `CHK(g, 1'b1, "read not answered")
    `CHK(d, e, "read data wrong")
  endtask

  task automatic t_reset;
    rd_chk(REG_CLK_CE, 8'h02);
    `CHK(mclk, cgr_mclk_t'({14'd2048, 1'b1}), "reset clock rate")
    rd_chk(REG_PCM, 8'h00);
    `CHK(pcm, cgr_pcm_cfg_t'(8'h00), "reset pcm setup")
    rd_chk(REG_RING, 8'h00);
    rd_chk(REG_BANK1, {4'h0, ext1});
    rd_chk(REG_BANK2, {4'h0, ext2});
    `CHK(b1_oe | b2_oe, 4'h0, "reset pin drive")
    `CHK(ch_en, 4'h0, "reset channel enables")
  endtask

  task automatic t_clock;
    logic [3:0] code [9] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'he, 4'h5, 4'hd,
                             4'h4, 4'hc};
    int         khz [9] = '{8192, 4096, 2048, 1536, 1544, 3072, 3088,
                            6144, 6176};
    logic [3:0] ce;
    local_req_in = 1'b1;
    for (int i = 0; i < 9; i++) begin
      ce = 4'(i * 5 + 1);
      host.wr(REG_CLK_CE, {ce, code[i]});
      cyc(1);
      `CHK(mclk, cgr_mclk_t'({14'(khz[i]), 1'b1}), "clock rate")
      `CHK(mclk_sel, code[i], "clock code")
      `CHK(ch_en, ce, "channel enables")
      `CHK(lreq_ch, ce, "gated local command")
      rd_chk(REG_CLK_CE, {ce, code[i]});
    end
    host.wr(REG_CLK_CE, 8'hf3);
    cyc(1);
    `CHK(mclk, cgr_mclk_t'(15'h0), "undefined clock code")
    local_req_in = 1'b0;
    #1;
    `CHK(lreq_ch, 4'h0, "no local command")
  endtask

  task automatic t_pcm;
    logic [2:0] k;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      v = {k, k[1:0], ~k};
      host.wr(REG_PCM, v);
      cyc(1);
      `CHK(pcm, cgr_pcm_cfg_t'(v), "pcm setup")
      rd_chk(REG_PCM, v);
    end
  endtask

  task automatic t_refuse;
    logic [7:0] d;
    logic       g;
    host.wr(7'h2b, 8'hff);
    host.rd(7'h2b, d, g);
    `CHK(g, 1'b0, "unmapped read answered")
  endtask

  task automatic t_status;
    // power-up pin levels must clear the hold-off filter first
    cyc(215);
    hook = 4'h5;
    gk   = 4'ha;
    // read-only place: write must leave no trace
    host.wr(REG_STATUS, 8'h3c);
    cyc(40);
    rd_chk(REG_STATUS, 8'h0f);
    cyc(200);
    rd_chk(REG_STATUS, 8'ha5);
  endtask

  task automatic t_banks;
    logic [6:0] a;
    logic [3:0] oe, out, ext;
    for (int b = 0; b < 2; b++) begin
      a = b ? REG_BANK2 : REG_BANK1;
      ext = b ? ext2 : ext1;
      host.wr(a, 8'h3a);
      cyc(3);
      oe  = b ? b2_oe : b1_oe;
      out = b ? b2_out : b1_out;
      `CHK(oe, 4'h3, "pin direction")
      `CHK(out & oe, 4'h2, "driven pin data")
      cyc(4);
      rd_chk(a, {4'h3, 4'h2 | (ext & 4'hc)});
      host.wr(a, 8'h0f);
      cyc(3);
      oe = b ? b2_oe : b1_oe;
      `CHK(oe, 4'h0, "pins back to input")
    end
  endtask

  task automatic t_ring;
    hook     = 4'hf;
    ring_req = 4'hf;
    cyc(215);
    host.wr(REG_RING, 8'h0e);
    cyc(4);
    `CHK(trip, 4'h0, "trip while on hook")
    `CHK(fa, 4'hf, "ring active high")
    `CHK(fb, 4'h0, "unpicked output idle")
    hook = 4'he;
    cyc(215);
    `CHK(trip, 4'h1, "trip on low hook")
    `CHK(fa, 4'he, "tripped ring stopped")
    host.wr(REG_RING, 8'h06);
    cyc(4);
    `CHK(trip, 4'h0, "trip while disabled")
    `CHK(fa, 4'hf, "ring kept when disabled")
    host.wr(REG_RING, 8'h8f);
    cyc(4);
    `CHK(fb, 4'h1, "ring active low")
    `CHK(fa, 4'hf, "inactive high level")
    `CHK(b3_lvl, 1'b1, "bank three idle level")
    host.wr(REG_RING, 8'h0d);
    cyc(4);
    `CHK(b3_force, 4'h1, "bank three override")
    b3_dir = 4'he;
    cyc(2);
    `CHK(b3_force, 4'h0, "bank three input left alone")
    host.wr(REG_RING, 8'h3e);
    cyc(4);
    `CHK(trip, 4'ha, "ground key active high")
    `CHK(fa, 4'h5, "ground key trip")
    rd_chk(REG_RING, 8'h3e);
    host.wr(REG_BANK1, 8'hff);
    host.wr(REG_RING, 8'h0b);
    cyc(4);
    `CHK(b1_out, 4'he, "bank one override")
    host.wr(REG_BANK2, 8'hff);
    host.wr(REG_RING, 8'h0c);
    cyc(4);
    `CHK(b2_out, 4'he, "bank two override")
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard far beyond the longest sequence
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    $display("[ERR] %0t run did not finish", $time);
    close_out();
  end

  initial begin
    rst_b_in     = 1'b0;
    local_req_in = 1'b0;
    hook         = 4'hf;
    gk           = 4'h0;
    ring_req     = 4'h0;
    ext1         = 4'h6;
    ext2         = 4'h9;
    b3_dir       = 4'hf;
    repeat (12) @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    t_reset();
    t_clock();
    t_pcm();
    t_refuse();
    t_status();
    t_banks();
    t_ring();
    close_out();
  end
endmodule
